// ### hdl/rsp_map.svh
// Register offsets, reset values and timing counts of the stop and reset policy block.
`ifndef RSP_MAP_SVH
`define RSP_MAP_SVH
`define RSP_OFS_POLICY 12'h000
`define RSP_OFS_CTRL 12'h004
`define RSP_OFS_STATUS 12'h008
`define RSP_OFS_LOSS_LIMIT 12'h00c
`define RSP_OFS_COMMAND 12'h010
`define RSP_POLICY_RST 5'h0e
`define RSP_CTRL_UNIT_PRIO_BIT 0
`define RSP_CTRL_RS485_BIT 1
`define RSP_CTRL_RST 2'h1
`define RSP_CMD_COMM_RESET_BIT 0
`define RSP_CLK_HZ 50000000
`define RSP_LOSS_TIME_MS 1000
`define RSP_LOSS_CYCLES (`RSP_CLK_HZ / 1000 * `RSP_LOSS_TIME_MS)
`endif

// ### hdl/rsp_pkg.sv
// Types shared by the stop and reset policy block.
package rsp_pkg;
    typedef enum logic [2:0] {
        RSP_MODE_PANEL = 3'h1,
        RSP_MODE_EXTERNAL = 3'h2,
        RSP_MODE_NETWORK = 3'h4
    } rsp_mode_t;
    typedef enum logic [2:0] {
        RSP_LOSS_UNARMED = 3'h1,
        RSP_LOSS_WATCH = 3'h2,
        RSP_LOSS_ALARM = 3'h4
    } rsp_loss_state_t;
    typedef struct packed {
        logic external_reset_input;
        logic forward_start_input;
        logic reverse_start_input;
        logic panel_present;
        logic unit_attached;
        logic builtin_stop_key;
        logic unit_stop_key;
        logic panel_reset_key;
        logic mode_toggle_key;
        logic external_mode_key;
    } rsp_pins_t;
endpackage : rsp_pkg

// ### hdl/rsp_policy.sv
// Reset acceptance, panel loss detection and panel stop policy with an AHB-Lite register slave.
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "rsp_map.svh"
module rsp_policy #(
    parameter logic [31:0] LOSS_CYCLES = 32'(`RSP_LOSS_CYCLES)
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pins from the terminals and the panel connector.
    input wire rsp_pkg::rsp_pins_t pins,
    // Drive state from the controller logic on this clock.
    input wire logic tripped,
    input wire logic running,
    input wire logic panel_jog,
    input wire rsp_pkg::rsp_mode_t op_mode,
    // Policy results.
    output logic reset_pulse,
    output logic output_shutoff,
    output logic thermal_clear,
    output logic brake_duty_clear,
    output logic decel_stop,
    output logic panel_loss_alarm,
    output logic panel_stop_latch,
    output logic start_inhibit
);
    function automatic logic policy_legal(input logic [4:0] p);
        policy_legal = (p <= 5'h03) || (p >= 5'h0e && p <= 5'h11);
    endfunction : policy_legal

    logic [4:0] policy_r;
    logic [1:0] ctrl_r;
    logic [31:0] loss_limit_r;
    logic comm_reset_r;
    rsp_pkg::rsp_pins_t pins_s1_r;
    rsp_pkg::rsp_pins_t pins_s2_r;
    rsp_pkg::rsp_pins_t pins_d_r;
    rsp_pkg::rsp_loss_state_t loss_state_r;
    rsp_pkg::rsp_loss_state_t loss_state_nxt;
    logic [31:0] loss_cnt_r;
    logic decel_r;

    // Pins cross into the clock domain before anything looks at them.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pins_s1_r <= '0;
            pins_s2_r <= '0;
            pins_d_r <= '0;
        end else begin
            pins_s1_r <= pins;
            pins_s2_r <= pins_s1_r;
            pins_d_r <= pins_s2_r;
        end
    end

    logic ext_reset_ev;
    logic panel_reset_ev;
    logic builtin_stop_ev;
    logic unit_stop_ev;
    logic toggle_ev;
    logic ext_key_ev;
    logic starts_off;
    assign ext_reset_ev = pins_s2_r.external_reset_input & ~pins_d_r.external_reset_input;
    assign panel_reset_ev = pins_s2_r.panel_reset_key & ~pins_d_r.panel_reset_key;
    assign builtin_stop_ev = pins_s2_r.builtin_stop_key & ~pins_d_r.builtin_stop_key;
    assign unit_stop_ev = pins_s2_r.unit_stop_key & ~pins_d_r.unit_stop_key;
    assign toggle_ev = pins_s2_r.mode_toggle_key & ~pins_d_r.mode_toggle_key;
    assign ext_key_ev = pins_s2_r.external_mode_key & ~pins_d_r.external_mode_key;
    assign starts_off = ~pins_s2_r.forward_start_input & ~pins_s2_r.reverse_start_input;

    // Policy decoding.
    logic reset_trip_only;
    logic loss_enabled;
    logic stop_all_modes;
    logic rs485_panel;
    logic unit_prio;
    assign reset_trip_only = policy_r[0];
    assign loss_enabled = (policy_r == 5'h02) || (policy_r == 5'h03) || policy_r[4];
    assign stop_all_modes = (policy_r >= 5'h0e);
    assign rs485_panel = ctrl_r[`RSP_CTRL_RS485_BIT];
    assign unit_prio = ctrl_r[`RSP_CTRL_UNIT_PRIO_BIT];

    // Reset acceptance.
    logic ext_or_comm_ok;
    logic panel_key_ok;
    logic reset_accept;
    assign ext_or_comm_ok = (ext_reset_ev | comm_reset_r) & (~reset_trip_only | tripped);
    assign panel_key_ok = panel_reset_ev & tripped;
    assign reset_accept = ext_or_comm_ok | panel_key_ok;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reset_pulse <= 1'b0;
            thermal_clear <= 1'b0;
            brake_duty_clear <= 1'b0;
        end else begin
            reset_pulse <= reset_accept;
            thermal_clear <= reset_accept;
            brake_duty_clear <= reset_accept;
        end
    end

    // Panel loss monitor: armed only once the panel has been seen after power-on.
    logic loss_detect;
    logic absent;
    assign loss_detect = loss_enabled & ~rs485_panel;
    assign absent = ~pins_s2_r.panel_present;

    always_comb begin
        loss_state_nxt = loss_state_r;
        case (loss_state_r)
            rsp_pkg::RSP_LOSS_UNARMED: begin
                if (!absent) begin
                    loss_state_nxt = rsp_pkg::RSP_LOSS_WATCH;
                end
            end
            rsp_pkg::RSP_LOSS_WATCH: begin
                if (absent && loss_detect && loss_cnt_r >= loss_limit_r) begin
                    loss_state_nxt = rsp_pkg::RSP_LOSS_ALARM;
                end
            end
            rsp_pkg::RSP_LOSS_ALARM: begin
                // Leaving the alarm needs the panel back and then a reset.
                if (reset_accept && !absent) begin
                    loss_state_nxt = rsp_pkg::RSP_LOSS_WATCH;
                end
            end
            default: begin
                loss_state_nxt = rsp_pkg::RSP_LOSS_UNARMED;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            loss_state_r <= rsp_pkg::RSP_LOSS_UNARMED;
        end else begin
            loss_state_r <= loss_state_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            loss_cnt_r <= 32'h0;
        end else if (!absent || !loss_detect || loss_state_r != rsp_pkg::RSP_LOSS_WATCH) begin
            loss_cnt_r <= 32'h0;
        end else if (loss_cnt_r < loss_limit_r) begin
            loss_cnt_r <= loss_cnt_r + 32'h1;
        end
    end

    logic alarm_now;
    assign alarm_now = (loss_state_nxt == rsp_pkg::RSP_LOSS_ALARM);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            panel_loss_alarm <= 1'b0;
            output_shutoff <= 1'b0;
        end else begin
            panel_loss_alarm <= alarm_now;
            output_shutoff <= alarm_now | reset_accept;
        end
    end

    // Panel stop. With the unit attached and given priority, the built-in panel is the unselected one.
    logic unit_selected;
    logic stop_unselected;
    logic stop_any;
    logic in_panel;
    logic stop_decel;
    logic latch_set;
    logic latch_clr;
    assign unit_selected = pins_s2_r.unit_attached & unit_prio;
    assign stop_unselected = unit_selected ? builtin_stop_ev : unit_stop_ev;
    assign stop_any = builtin_stop_ev | unit_stop_ev;
    assign in_panel = (op_mode == rsp_pkg::RSP_MODE_PANEL);
    assign stop_decel = stop_any & (in_panel | stop_all_modes);
    assign latch_set = stop_all_modes & ((~in_panel & stop_any)
        | (in_panel & stop_unselected)
        | (in_panel & rs485_panel & builtin_stop_ev));
    assign latch_clr = ext_or_comm_ok
        | (starts_off & ~running & (toggle_ev | ext_key_ev));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            panel_stop_latch <= 1'b0;
        end else if (latch_set) begin
            panel_stop_latch <= 1'b1;
        end else if (latch_clr) begin
            panel_stop_latch <= 1'b0;
        end
    end

    // A panel stop ramps down in panel mode, or in any mode under policy 5'h0e to 5'h11; a coasting stop method does not apply to it.
    logic jog_loss;
    assign jog_loss = panel_jog & absent & ~loss_enabled & (loss_state_r != rsp_pkg::RSP_LOSS_UNARMED);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            decel_r <= 1'b0;
        end else if (stop_decel || jog_loss) begin
            decel_r <= 1'b1;
        end else if (!running) begin
            decel_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            decel_stop <= 1'b0;
            start_inhibit <= 1'b0;
        end else begin
            decel_stop <= stop_decel | jog_loss | decel_r;
            start_inhibit <= (panel_stop_latch & ~latch_clr) | latch_set | alarm_now;
        end
    end

    // AHB-Lite slave. Writes have no wait state; reads take one so a read right after a write sees it.
    logic addr_ok;
    logic wr_pend_r;
    logic rd_pend_r;
    logic [11:0] addr_r;
    assign addr_ok = hsel & hready & htrans[1];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 12'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (hready) begin
                wr_pend_r <= addr_ok & hwrite;
                if (addr_ok) begin
                    addr_r <= haddr[11:0];
                end
            end
            rd_pend_r <= addr_ok & ~hwrite;
            hreadyout <= ~(addr_ok & ~hwrite);
        end
    end

    logic wr_en;
    assign wr_en = wr_pend_r & hready;

    // No parameter clear reaches the policy; only power-on reset returns it to 5'h0e.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            policy_r <= `RSP_POLICY_RST;
        end else if (wr_en && addr_r == `RSP_OFS_POLICY && policy_legal(hwdata[4:0]) && hwdata[31:5] == 27'h0) begin
            policy_r <= hwdata[4:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_r <= `RSP_CTRL_RST;
            loss_limit_r <= LOSS_CYCLES;
            comm_reset_r <= 1'b0;
        end else begin
            comm_reset_r <= wr_en && addr_r == `RSP_OFS_COMMAND && hwdata[`RSP_CMD_COMM_RESET_BIT];
            if (wr_en && addr_r == `RSP_OFS_CTRL) begin
                ctrl_r <= hwdata[1:0];
            end
            if (wr_en && addr_r == `RSP_OFS_LOSS_LIMIT) begin
                loss_limit_r <= hwdata;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0;
        end else if (rd_pend_r) begin
            case (addr_r)
                `RSP_OFS_POLICY: hrdata <= {27'h0, policy_r};
                `RSP_OFS_CTRL: hrdata <= {30'h0, ctrl_r};
                `RSP_OFS_STATUS: hrdata <= {25'h0, start_inhibit, decel_stop, pins_s2_r.panel_present,
                    loss_state_r == rsp_pkg::RSP_LOSS_WATCH, tripped, panel_stop_latch, panel_loss_alarm};
                `RSP_OFS_LOSS_LIMIT: hrdata <= loss_limit_r;
                default: hrdata <= 32'h0;
            endcase
        end
    end

    // Checks.
    sequence s_absent_run;
        absent && loss_detect && loss_state_r == rsp_pkg::RSP_LOSS_WATCH && loss_cnt_r >= loss_limit_r;
    endsequence
    sequence s_alarm_up;
        ##1 panel_loss_alarm && output_shutoff;
    endsequence

    a_policy_legal: assert property (@(posedge clock) disable iff (rst) policy_legal(policy_r))
        else $error("policy holds an illegal value");
    a_reset_trip_only: assert property (@(posedge clock) disable iff (rst)
        (reset_trip_only && !tripped && !panel_key_ok && reset_accept) |-> 1'b0)
        else $error("reset accepted outside a trip");
    a_reset_any_time: assert property (@(posedge clock) disable iff (rst)
        (!reset_trip_only && ext_reset_ev) |=> (reset_pulse && thermal_clear && brake_duty_clear))
        else $error("reset input not accepted");
    a_panel_key_trip: assert property (@(posedge clock) disable iff (rst)
        (panel_reset_ev && !tripped && !ext_reset_ev && !comm_reset_r) |=> !reset_pulse)
        else $error("panel reset key acted without a trip");
    a_loss_alarm_up: assert property (@(posedge clock) disable iff (rst) s_absent_run |-> s_alarm_up)
        else $error("loss alarm not raised at the limit");
    a_loss_needs_en: assert property (@(posedge clock) disable iff (rst)
        $rose(panel_loss_alarm) |-> $past(loss_detect) && $past(absent))
        else $error("loss alarm with detection disabled");
    a_ps_low_policy: assert property (@(posedge clock) disable iff (rst)
        (!stop_all_modes && !panel_stop_latch) |=> !panel_stop_latch)
        else $error("panel stop latch set under policy 0 to 3");
    a_ps_no_alarm: assert property (@(posedge clock) disable iff (rst)
        (latch_set && !alarm_now && !panel_loss_alarm) |=> !panel_loss_alarm && panel_stop_latch)
        else $error("panel stop raised an alarm");
    a_ps_inhibit: assert property (@(posedge clock) disable iff (rst)
        panel_stop_latch && !latch_clr |=> start_inhibit)
        else $error("start not inhibited while latched");
    a_ps_decel: assert property (@(posedge clock) disable iff (rst)
        (stop_any && stop_all_modes) |=> decel_stop [*1] ##1 (decel_stop || !running))
        else $error("panel stop did not decelerate");
    a_latch_clear: assert property (@(posedge clock) disable iff (rst)
        (latch_clr && !latch_set) |=> !panel_stop_latch)
        else $error("panel stop latch not cleared");
    a_jog_decel: assert property (@(posedge clock) disable iff (rst) jog_loss |=> decel_stop)
        else $error("panel loss in jog did not decelerate");
    a_rs485_no_loss: assert property (@(posedge clock) disable iff (rst)
        (rs485_panel && loss_state_r != rsp_pkg::RSP_LOSS_ALARM) |=> !panel_loss_alarm)
        else $error("loss alarm with RS485 on the panel connector");
    a_cnt_cleared: assert property (@(posedge clock) disable iff (rst) !absent |=> loss_cnt_r == 32'h0)
        else $error("absence counter not cleared");
    a_unsel_latch: assert property (@(posedge clock) disable iff (rst)
        (stop_all_modes && in_panel && stop_unselected) |=> panel_stop_latch)
        else $error("unselected panel stop did not latch");
endmodule : rsp_policy

// ### verification/rsp_panel_model.sv
// Behavioural operator panel and terminal inputs that drive the policy block's pins.
`timescale 1ns/1ns
module rsp_panel_model (
    // Clock.
    input wire logic clock,
    // Pins towards the block.
    output rsp_pkg::rsp_pins_t pins
);
    logic [9:0] p = 10'h000;
    assign pins = rsp_pkg::rsp_pins_t'(p);
    task automatic level(input int b, input logic v);
        @(posedge clock);
        p[b] <= v;
    endtask : level
    // Keys are held five cycles so the two stage synchroniser sees every press.
    task automatic tap(input int b);
        if (b == 9 || b == 1 || b == 0) begin
            @(posedge clock);
            p[8:7] <= 2'h0;
        end
        level(b, 1'b1);
        repeat (5) @(posedge clock);
        p[b] <= 1'b0;
    endtask : tap
endmodule : rsp_panel_model

// ### verification/tb.sv
// Self-checking bench for the stop and reset policy block.
`timescale 1ns/1ns
module tb;
    localparam logic [31:0] LIM = 32'h14;
    localparam int XRST = 9, PRES = 6, UNIT = 5, BSTOP = 4, PRST = 2, TOG = 1;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, v;
    logic [1:0] htrans = 2'h0;
    logic tripped = 1'b0, running = 1'b0, panel_jog = 1'b0;
    logic reset_pulse, output_shutoff, thermal_clear, brake_duty_clear;
    logic decel_stop, panel_loss_alarm, panel_stop_latch, start_inhibit;
    rsp_pkg::rsp_mode_t op_mode = rsp_pkg::RSP_MODE_EXTERNAL;
    rsp_pkg::rsp_pins_t pins;
    int n_errors = 0, num_checks = 0, n_rp = 0, n_full = 0, pol, e, exp_reg = 14;
    int pols[8] = '{0, 1, 2, 3, 14, 15, 16, 17};
    int lp[5] = '{0, 2, 14, 16, 16};
    integer seed = 32'h428c3c07;

    rsp_panel_model pm (.clock(clock), .pins(pins));
    rsp_policy #(.LOSS_CYCLES(LIM)) DUT (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .tripped(tripped),
        .running(running), .panel_jog(panel_jog), .op_mode(op_mode), .reset_pulse(reset_pulse),
        .output_shutoff(output_shutoff), .thermal_clear(thermal_clear),
        .brake_duty_clear(brake_duty_clear), .decel_stop(decel_stop),
        .panel_loss_alarm(panel_loss_alarm), .panel_stop_latch(panel_stop_latch),
        .start_inhibit(start_inhibit));

    initial begin
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        if (reset_pulse === 1'b1) begin
            n_rp++;
            if ({thermal_clear, brake_duty_clear, output_shutoff} === 3'h7) n_full++;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Called just after a rising edge; each phase is held until hready is sampled high.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    // Source 0 is the terminal reset, 1 the panel reset key, 2 the reset command.
    task automatic try_rst(input int src, input int exp);
        int a, b;
        a = n_rp;
        b = n_full;
        if (src == 2) bus(1'b1, 32'h10, 32'h1);
        else pm.tap(src == 0 ? XRST : PRST);
        repeat (12) @(posedge clock);
        chk("reset pulses", n_rp - a, exp);
        chk("reset clears", n_full - b, exp);
    endtask : try_rst

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    initial begin
        #1000000;
        n_errors++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        bus(1'b0, 32'h0, 32'h0);
        chk("policy", rd, 32'he);
        bus(1'b0, 32'h4, 32'h0);
        chk("ctrl", rd, 32'h1);
        bus(1'b0, 32'hc, 32'h0);
        chk("limit", rd, LIM);
        bus(1'b1, 32'hc, 32'h33);
        bus(1'b0, 32'hc, 32'h0);
        chk("limit write", rd, 32'h33);
        bus(1'b1, 32'hc, LIM);
        chk("hresp", hresp, 32'h0);
        bus(1'b0, 32'h20, 32'h0);
        chk("unmapped", rd, 32'h0);
        repeat (3 * LIM) @(posedge clock);
        chk("loss at power on", panel_loss_alarm, 1'b0);
        $display("test reset values done");
        for (int i = 0; i < 40; i++) begin
            v = i < 32 ? 32'(i) : $random(seed);
            if (v < 4 || (v > 13 && v < 18)) exp_reg = v;
            bus(1'b1, 32'h0, v);
            bus(1'b0, 32'h0, 32'h0);
            chk("policy write", rd, exp_reg);
        end
        $display("test policy writes done");
        for (int i = 0; i < 16; i++) begin
            pol = pols[i % 8];
            bus(1'b1, 32'h0, pol);
            tripped <= i > 7;
            running <= 1'b1;
            e = (i > 7 || pol % 2 == 0);
            try_rst(0, e);
            try_rst(2, e);
            try_rst(1, i > 7);
        end
        tripped <= 1'b0;
        running <= 1'b0;
        $display("test reset acceptance done");
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 32'h0, lp[i]);
            bus(1'b1, 32'h4, i == 4 ? 32'h3 : 32'h1);
            pm.level(PRES, 1'b1);
            repeat (10) @(posedge clock);
            pm.level(PRES, 1'b0);
            repeat (LIM - 4) @(posedge clock);
            chk("early loss", panel_loss_alarm, 1'b0);
            repeat (20) @(posedge clock);
            e = (lp[i] == 2 || lp[i] == 16) && i < 4;
            chk("loss alarm", panel_loss_alarm, e);
            chk("loss shutoff", output_shutoff, e);
            pm.level(PRES, 1'b1);
            try_rst(0, 1);
            chk("loss cleared", panel_loss_alarm, 1'b0);
        end
        bus(1'b1, 32'h4, 32'h1);
        bus(1'b1, 32'h0, 32'he);
        running <= 1'b1;
        panel_jog <= 1'b1;
        op_mode <= rsp_pkg::RSP_MODE_PANEL;
        pm.level(PRES, 1'b0);
        repeat (LIM + 16) @(posedge clock);
        chk("jog loss decel", decel_stop, 1'b1);
        running <= 1'b0;
        panel_jog <= 1'b0;
        pm.level(PRES, 1'b1);
        $display("test panel loss done");
        for (int i = 0; i < 6; i++) begin
            pol = i < 3 ? 0 : 14;
            e = pol == 14 && i % 3 != 0;
            bus(1'b1, 32'h0, pol);
            op_mode <= rsp_pkg::rsp_mode_t'(3'h1 << (i % 3));
            running <= 1'b1;
            pm.tap(BSTOP);
            repeat (8) @(posedge clock);
            chk("stop decel", decel_stop, i % 3 == 0 || e);
            chk("stop latch", panel_stop_latch, e);
            chk("inhibit", start_inhibit, e);
            chk("stop alarm", panel_loss_alarm, 1'b0);
            bus(1'b0, 32'h8, 32'h0);
            chk("status", rd, 32'h18 | (e ? 32'h42 : 32'h0) | ((i % 3 == 0 || e) ? 32'h20 : 32'h0));
            pm.tap(TOG);
            repeat (8) @(posedge clock);
            chk("latch while running", panel_stop_latch, e);
            running <= 1'b0;
            pm.tap(i == 4 ? XRST : (i == 5 ? 0 : TOG));
            repeat (8) @(posedge clock);
            chk("latch cleared", panel_stop_latch, 1'b0);
        end
        op_mode <= rsp_pkg::RSP_MODE_PANEL;
        for (int i = 0; i < 2; i++) begin
            pm.level(UNIT, i == 0);
            bus(1'b1, 32'h4, i == 0 ? 32'h1 : 32'h3);
            running <= 1'b1;
            pm.tap(BSTOP);
            repeat (8) @(posedge clock);
            chk("unselected stop latch", panel_stop_latch, 1'b1);
            chk("unselected stop decel", decel_stop, 1'b1);
            running <= 1'b0;
            pm.tap(TOG);
            repeat (8) @(posedge clock);
            chk("unit latch cleared", panel_stop_latch, 1'b0);
        end
        $display("test panel stop done");
        stop_test();
    end
endmodule : tb
